// [common/cvd_pkg.sv]
package cvd_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] CVD_OFF_CONVERTER_CONTROL = 8'h00;
  localparam logic [7:0] CVD_OFF_POLARITY_CONTROL = 8'h04;
  localparam logic [7:0] CVD_OFF_STAGE_STATUS = 8'h08;
  localparam logic [7:0] CVD_OFF_PRECHARGE_TIME = 8'h0C;
  localparam logic [7:0] CVD_OFF_ACQUISITION_TIME = 8'h10;
  localparam logic [7:0] CVD_OFF_GUARD_RING_CONTROL = 8'h14;

  // Converter control fields.
  localparam int CVD_BIT_CONVERTER_ENABLE = 0;
  localparam int CVD_BIT_GO = 1;
  localparam int CVD_BIT_RC_CLOCK_SELECT = 2;

  // Polarity control fields.
  localparam int CVD_BIT_EXT_PRECHARGE_POLARITY = 7;
  localparam int CVD_BIT_INT_PRECHARGE_POLARITY = 6;
  localparam int CVD_BIT_BUS_PIN_OUTPUT_ENABLE = 4;
  localparam int CVD_BIT_BUS_PIN_OVERRIDE_ENABLE = 3;
  localparam int CVD_BIT_SECOND_PASS_INVERT_ENABLE = 1;
  localparam int CVD_BIT_DOUBLE_SAMPLE_ENABLE = 0;
  localparam logic [7:0] CVD_POLARITY_MASK = 8'hDB;

  // Stage status fields.
  localparam int CVD_BIT_CONVERSION_INDEX = 2;
  localparam int CVD_POS_SEQUENCE_STAGE = 0;

  // Guard ring control fields.
  localparam int CVD_BIT_GUARD_B_OUTPUT_ENABLE = 7;
  localparam int CVD_BIT_GUARD_A_OUTPUT_ENABLE = 6;
  localparam int CVD_BIT_GUARD_START_POLARITY = 5;

  // Reset values.
  localparam logic [7:0] CVD_RST_POLARITY_CONTROL = 8'h00;
  localparam logic [6:0] CVD_RST_PRECHARGE_TIME = 7'h00;
  localparam logic [6:0] CVD_RST_ACQUISITION_TIME = 7'h00;
  localparam logic [2:0] CVD_RST_GUARD_RING_CONTROL = 3'h0;

  // Stage codes as reported in the status register.
  localparam logic [1:0] CVD_CODE_IDLE = 2'h0;
  localparam logic [1:0] CVD_CODE_PRECHARGE = 2'h1;
  localparam logic [1:0] CVD_CODE_ACQUISITION = 2'h2;
  localparam logic [1:0] CVD_CODE_CONVERSION = 2'h3;

  typedef enum logic [3:0] {
    CVD_ST_IDLE = 4'b0001,
    CVD_ST_PRECHARGE = 4'b0010,
    CVD_ST_ACQUISITION = 4'b0100,
    CVD_ST_CONVERSION = 4'b1000
  } cvd_stage_e;

  typedef struct packed {
    logic ext_precharge_active;
    logic ext_precharge_level;
    logic int_precharge_active;
    logic int_precharge_level;
    logic bus_pass_gate;
    logic bus_pin_out;
    logic bus_pin_oe;
    logic guard_a_out;
    logic guard_a_oe;
    logic guard_b_out;
    logic guard_b_oe;
  } cvd_pins_s;

  typedef struct packed {
    logic converter_enable;
    logic go;
    logic rc_sel;
    logic [7:0] polarity;
    logic [6:0] precharge_cycles;
    logic [6:0] acquisition_cycles;
    logic [2:0] guard;
    cvd_stage_e stage;
    logic [6:0] cnt;
    logic second;
    logic guard_a;
    logic [2:0] rc_sync;
    logic rc_stable;
    logic [31:0] rdata;
  } cvd_state_s;

endpackage

// [hw/cvd_sequence_control.sv]
`timescale 1ns/1ps
module cvd_sequence_control
  import cvd_pkg::*;
(
  input wire logic pclk, // APB clock, 100 MHz
  input wire logic presetn, // Asynchronous reset
  input wire logic clk_en, // Freezes all state while low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic rc_clk_pin, // Dedicated RC oscillator
  input wire logic convert_done, // Converter finished its result
  output logic convert_active, // Conversion stage running
  output logic result_select, // Result pair being filled
  output cvd_pins_s pins // Analog switch and pin controls
);

  cvd_state_s s_q;
  cvd_state_s s_d;
  logic rc_rise;
  logic tick;
  logic wr_en;
  logic inv_now;
  logic start_pass;
  logic to_acq;

  function automatic logic [1:0] stage_code(input cvd_stage_e st);
    logic [1:0] c;
    c = CVD_CODE_IDLE;
    unique case (st)
      CVD_ST_IDLE: c = CVD_CODE_IDLE;
      CVD_ST_PRECHARGE: c = CVD_CODE_PRECHARGE;
      CVD_ST_ACQUISITION: c = CVD_CODE_ACQUISITION;
      CVD_ST_CONVERSION: c = CVD_CODE_CONVERSION;
      default: c = CVD_CODE_IDLE;
    endcase
    return c;
  endfunction

  function automatic logic addr_hit(input logic [7:0] a);
    return a == CVD_OFF_CONVERTER_CONTROL || a == CVD_OFF_POLARITY_CONTROL ||
      a == CVD_OFF_STAGE_STATUS || a == CVD_OFF_PRECHARGE_TIME ||
      a == CVD_OFF_ACQUISITION_TIME || a == CVD_OFF_GUARD_RING_CONTROL;
  endfunction

  // Inversion only on the applied values of the second pass.
  function automatic logic pass_invert(input cvd_state_s s, input logic sec);
    return sec && s.polarity[CVD_BIT_DOUBLE_SAMPLE_ENABLE] &&
      s.polarity[CVD_BIT_SECOND_PASS_INVERT_ENABLE];
  endfunction

  function automatic logic [31:0] read_mux(input cvd_state_s s,
                                           input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      CVD_OFF_CONVERTER_CONTROL: begin
        r[CVD_BIT_CONVERTER_ENABLE] = s.converter_enable;
        r[CVD_BIT_GO] = s.go;
        r[CVD_BIT_RC_CLOCK_SELECT] = s.rc_sel;
      end
      CVD_OFF_POLARITY_CONTROL: r[7:0] = s.polarity;
      CVD_OFF_STAGE_STATUS: begin
        r[CVD_BIT_CONVERSION_INDEX] = s.second && s.go;
        r[CVD_POS_SEQUENCE_STAGE +: 2] = stage_code(s.stage);
      end
      CVD_OFF_PRECHARGE_TIME: r[6:0] = s.precharge_cycles;
      CVD_OFF_ACQUISITION_TIME: r[6:0] = s.acquisition_cycles;
      CVD_OFF_GUARD_RING_CONTROL: r[7:5] = s.guard;
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // The RC clock is a pin from another domain; only the agreeing second
  // and third stages may announce an edge.
  assign rc_rise = (s_q.rc_sync[2] == s_q.rc_sync[1]) && s_q.rc_sync[1] &&
    !s_q.rc_stable;
  assign tick = s_q.rc_sel ? rc_rise : 1'b1;
  assign wr_en = psel && penable && pwrite && addr_hit(paddr);
  assign inv_now = pass_invert(s_q, s_q.second);

  always_comb begin
    s_d = s_q;
    start_pass = 1'b0;
    to_acq = 1'b0;
    s_d.rc_sync = {s_q.rc_sync[1:0], rc_clk_pin};
    if (s_q.rc_sync[2] == s_q.rc_sync[1]) begin
      s_d.rc_stable = s_q.rc_sync[1];
    end
    unique case (s_q.stage)
      CVD_ST_IDLE: begin
        if (s_q.go && s_q.converter_enable) begin
          start_pass = 1'b1;
        end
      end
      CVD_ST_PRECHARGE: begin
        if (tick) begin
          if (s_q.cnt == 7'h01) begin
            to_acq = 1'b1;
          end else begin
            s_d.cnt = s_q.cnt - 7'h01;
          end
        end
      end
      CVD_ST_ACQUISITION: begin
        if (tick) begin
          if (s_q.cnt == 7'h01) begin
            s_d.stage = CVD_ST_CONVERSION;
          end else begin
            s_d.cnt = s_q.cnt - 7'h01;
          end
        end
      end
      CVD_ST_CONVERSION: begin
        if (convert_done) begin
          if (s_q.polarity[CVD_BIT_DOUBLE_SAMPLE_ENABLE] && !s_q.second) begin
            s_d.second = 1'b1;
            start_pass = 1'b1;
          end else begin
            s_d.go = 1'b0;
            s_d.second = 1'b0;
            s_d.stage = CVD_ST_IDLE;
          end
        end
      end
      default: s_d.stage = CVD_ST_IDLE;
    endcase
    if (start_pass) begin
      s_d.guard_a = s_q.guard[CVD_BIT_GUARD_START_POLARITY - 5] ^
        pass_invert(s_q, s_d.second);
      if (s_q.precharge_cycles != 7'h00) begin
        s_d.stage = CVD_ST_PRECHARGE;
        s_d.cnt = s_q.precharge_cycles;
      end else begin
        to_acq = 1'b1;
      end
    end
    if (to_acq) begin
      if (s_q.acquisition_cycles != 7'h00) begin
        s_d.stage = CVD_ST_ACQUISITION;
        s_d.cnt = s_q.acquisition_cycles;
        s_d.guard_a = !s_d.guard_a;
      end else begin
        s_d.stage = CVD_ST_CONVERSION;
      end
    end
    // Clearing the busy flag or the enable abandons the sequence at once.
    if (!s_q.converter_enable) begin
      s_d.go = 1'b0;
      s_d.second = 1'b0;
      s_d.stage = CVD_ST_IDLE;
    end else if (!s_q.go && s_q.stage != CVD_ST_IDLE) begin
      s_d.second = 1'b0;
      s_d.stage = CVD_ST_IDLE;
    end
    // Bus writes come last so a software set beats a hardware clear.
    if (wr_en) begin
      unique case (paddr)
        CVD_OFF_CONVERTER_CONTROL: begin
          s_d.converter_enable = pwdata[CVD_BIT_CONVERTER_ENABLE];
          s_d.go = pwdata[CVD_BIT_GO] && pwdata[CVD_BIT_CONVERTER_ENABLE];
          s_d.rc_sel = pwdata[CVD_BIT_RC_CLOCK_SELECT];
        end
        CVD_OFF_POLARITY_CONTROL:
          s_d.polarity = pwdata[7:0] & CVD_POLARITY_MASK;
        CVD_OFF_PRECHARGE_TIME: s_d.precharge_cycles = pwdata[6:0];
        CVD_OFF_ACQUISITION_TIME: s_d.acquisition_cycles = pwdata[6:0];
        CVD_OFF_GUARD_RING_CONTROL: s_d.guard = pwdata[7:5];
        default: s_d.stage = s_d.stage;
      endcase
    end
    if (psel && !penable) begin
      s_d.rdata = read_mux(s_q, paddr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{converter_enable: 1'b0, go: 1'b0, rc_sel: 1'b0,
               polarity: CVD_RST_POLARITY_CONTROL,
               precharge_cycles: CVD_RST_PRECHARGE_TIME,
               acquisition_cycles: CVD_RST_ACQUISITION_TIME,
               guard: CVD_RST_GUARD_RING_CONTROL, stage: CVD_ST_IDLE,
               cnt: 7'h00, second: 1'b0, guard_a: 1'b0, rc_sync: 3'h0,
               rc_stable: 1'b0, rdata: 32'h0000_0000};
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit(paddr);
  assign prdata = s_q.rdata;
  assign convert_active = s_q.stage == CVD_ST_CONVERSION;
  assign result_select = s_q.second && s_q.go;

  always_comb begin
    logic pre;
    logic on;
    pre = s_q.stage == CVD_ST_PRECHARGE;
    on = s_q.converter_enable;
    pins.ext_precharge_active = pre;
    pins.ext_precharge_level =
      s_q.polarity[CVD_BIT_EXT_PRECHARGE_POLARITY] ^ inv_now;
    pins.int_precharge_active = pre;
    pins.int_precharge_level =
      s_q.polarity[CVD_BIT_INT_PRECHARGE_POLARITY] ^ inv_now;
    pins.bus_pin_oe = on && pre &&
      s_q.polarity[CVD_BIT_BUS_PIN_OVERRIDE_ENABLE];
    pins.bus_pin_out = pins.int_precharge_level;
    pins.bus_pass_gate = on && !pins.bus_pin_oe &&
      s_q.polarity[CVD_BIT_BUS_PIN_OUTPUT_ENABLE];
    // Guard B follows the start polarity, inverted in an inverted second pass; only A flips at acquisition.
    pins.guard_a_out = s_q.guard_a;
    pins.guard_a_oe = on &&
      s_q.guard[CVD_BIT_GUARD_A_OUTPUT_ENABLE - 5];
    pins.guard_b_out = s_q.stage == CVD_ST_IDLE ?
      s_q.guard[CVD_BIT_GUARD_START_POLARITY - 5] :
      s_q.guard[CVD_BIT_GUARD_START_POLARITY - 5] ^ inv_now;
    pins.guard_b_oe = on &&
      s_q.guard[CVD_BIT_GUARD_B_OUTPUT_ENABLE - 5];
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_EXT_LEVEL: assert property (
    s_q.stage == CVD_ST_PRECHARGE |-> pins.ext_precharge_level ==
      (s_q.polarity[CVD_BIT_EXT_PRECHARGE_POLARITY] ^ (s_q.second &&
      s_q.polarity[CVD_BIT_DOUBLE_SAMPLE_ENABLE] &&
      s_q.polarity[CVD_BIT_SECOND_PASS_INVERT_ENABLE])))
    else $error("External pre-charge level wrong.");

  AST_INT_LEVEL: assert property (
    (s_q.stage == CVD_ST_PRECHARGE && !s_q.second) |->
      pins.int_precharge_level == s_q.polarity[CVD_BIT_INT_PRECHARGE_POLARITY])
    else $error("Internal pre-charge level wrong.");

  AST_PASS_GATE: assert property (
    (s_q.converter_enable && s_q.stage != CVD_ST_PRECHARGE) |->
      pins.bus_pass_gate == s_q.polarity[CVD_BIT_BUS_PIN_OUTPUT_ENABLE])
    else $error("Bus pass gate wrong.");

  AST_OVERRIDE: assert property (
    (s_q.stage == CVD_ST_PRECHARGE && s_q.converter_enable &&
     s_q.polarity[CVD_BIT_BUS_PIN_OVERRIDE_ENABLE]) |->
      pins.bus_pin_oe && !pins.bus_pass_gate &&
      pins.bus_pin_out == pins.int_precharge_level)
    else $error("Bus pin override wrong.");

  AST_DOUBLE: assert property (
    (clk_en && convert_done && s_q.stage == CVD_ST_CONVERSION &&
     s_q.converter_enable && s_q.go && !s_q.second &&
     s_q.polarity[CVD_BIT_DOUBLE_SAMPLE_ENABLE]) |=>
      s_q.go && s_q.second && s_q.stage != CVD_ST_IDLE)
    else $error("Second conversion did not follow.");

  AST_SINGLE_DONE: assert property (
    (clk_en && convert_done && s_q.stage == CVD_ST_CONVERSION &&
     !s_q.polarity[CVD_BIT_DOUBLE_SAMPLE_ENABLE] && !wr_en) |=>
      !s_q.go && s_q.stage == CVD_ST_IDLE)
    else $error("Busy flag not cleared after conversion.");

  AST_INDEX_IDLE: assert property (
    !s_q.go |-> !result_select)
    else $error("Index set while idle.");

  AST_SKIP_PRE: assert property (
    (clk_en && s_q.stage == CVD_ST_IDLE && s_q.go && s_q.converter_enable &&
     s_q.precharge_cycles == 7'h00) |=> s_q.stage != CVD_ST_PRECHARGE)
    else $error("Zero pre-charge was not skipped.");

  AST_PRE_END: assert property (
    (clk_en && s_q.stage == CVD_ST_PRECHARGE && tick && s_q.cnt == 7'h01 &&
     s_q.go && s_q.converter_enable) |=> s_q.stage != CVD_ST_PRECHARGE)
    else $error("Pre-charge overran its count.");

  AST_GUARD_TOGGLE: assert property (
    (clk_en && s_q.stage == CVD_ST_PRECHARGE && s_q.go &&
     s_q.converter_enable && tick && s_q.cnt == 7'h01 &&
     s_q.acquisition_cycles != 7'h00) |=>
      s_q.stage == CVD_ST_ACQUISITION && pins.guard_a_out != $past(s_q.guard_a))
    else $error("Guard A did not toggle at acquisition.");

  AST_GUARD_OE: assert property (
    !s_q.converter_enable |-> !pins.guard_a_oe && !pins.guard_b_oe &&
      (s_q.stage == CVD_ST_IDLE || $past(s_q.converter_enable) ||
      !$past(clk_en)))
    else $error("Guard drive with converter disabled.");

  AST_INT_INVERT: assert property (
    (s_q.stage == CVD_ST_PRECHARGE && s_q.second &&
     s_q.polarity[CVD_BIT_DOUBLE_SAMPLE_ENABLE] &&
     s_q.polarity[CVD_BIT_SECOND_PASS_INVERT_ENABLE]) |->
      pins.int_precharge_level != s_q.polarity[CVD_BIT_INT_PRECHARGE_POLARITY])
    else $error("Second pass internal level not inverted.");

  AST_NO_INVERT: assert property (
    !s_q.polarity[CVD_BIT_DOUBLE_SAMPLE_ENABLE] |->
      pins.ext_precharge_level ==
      s_q.polarity[CVD_BIT_EXT_PRECHARGE_POLARITY] &&
      pins.int_precharge_level ==
      s_q.polarity[CVD_BIT_INT_PRECHARGE_POLARITY])
    else $error("Polarity inverted without double sample.");

  AST_INDEX_CLEAR: assert property (
    s_q.stage == CVD_ST_IDLE |-> !s_q.second)
    else $error("Index left set in idle.");

  AST_BUSY_HOLD: assert property (
    (clk_en && convert_done && s_q.stage == CVD_ST_CONVERSION &&
     s_q.converter_enable && s_q.go && !s_q.second && !wr_en &&
     s_q.polarity[CVD_BIT_DOUBLE_SAMPLE_ENABLE]) |=> s_q.go && result_select)
    else $error("Busy flag dropped between passes.");

  AST_PRE_START: assert property (
    (clk_en && s_q.stage == CVD_ST_IDLE && s_q.go && s_q.converter_enable &&
     s_q.precharge_cycles != 7'h00) |=> s_q.stage == CVD_ST_PRECHARGE &&
      s_q.cnt == $past(s_q.precharge_cycles))
    else $error("Pre-charge did not start with its count.");

  AST_ACQ_END: assert property (
    (clk_en && s_q.stage == CVD_ST_ACQUISITION && tick && s_q.cnt == 7'h01 &&
     s_q.go && s_q.converter_enable) |=> s_q.stage == CVD_ST_CONVERSION)
    else $error("Acquisition overran its count.");

  AST_SKIP_ACQ: assert property (
    (clk_en && s_q.stage == CVD_ST_PRECHARGE && tick && s_q.cnt == 7'h01 &&
     s_q.go && s_q.converter_enable && s_q.acquisition_cycles == 7'h00) |=>
      s_q.stage == CVD_ST_CONVERSION)
    else $error("Zero acquisition was not skipped.");

  AST_NO_BACKSTEP: assert property (
    s_q.stage == CVD_ST_ACQUISITION |=> s_q.stage != CVD_ST_PRECHARGE)
    else $error("Acquisition stepped back to pre-charge.");

  AST_GUARD_START: assert property (
    (s_q.stage == CVD_ST_PRECHARGE && !s_q.second) |->
      pins.guard_b_out == s_q.guard[CVD_BIT_GUARD_START_POLARITY - 5])
    else $error("Guard start polarity wrong.");

  AST_GUARD_DRIVE: assert property (
    s_q.converter_enable |->
      pins.guard_a_oe == s_q.guard[CVD_BIT_GUARD_A_OUTPUT_ENABLE - 5] &&
      pins.guard_b_oe == s_q.guard[CVD_BIT_GUARD_B_OUTPUT_ENABLE - 5])
    else $error("Guard drive does not follow its enables.");

  AST_DISABLE_IDLE: assert property (
    (clk_en && !s_q.converter_enable && !wr_en) |=>
      s_q.stage == CVD_ST_IDLE && !s_q.go)
    else $error("Disabled converter left running.");

  AST_DISABLE_PINS: assert property (
    !s_q.converter_enable |-> !pins.bus_pin_oe && !pins.bus_pass_gate)
    else $error("Bus pin connected with converter disabled.");

  AST_OVERRIDE_OFF: assert property (
    !s_q.polarity[CVD_BIT_BUS_PIN_OVERRIDE_ENABLE] |-> !pins.bus_pin_oe)
    else $error("Bus pin driven without override.");

endmodule

// [testbench/cvd_conv_model.sv]
`timescale 1ns/1ps
// Stands in for the converter behind the sequencer. A short latency gives
// a prompt answer, a long one keeps the conversion stage open for reads.
module cvd_conv_model (
  input wire logic pclk, // Clock
  input wire logic presetn, // Asynchronous reset
  input wire logic convert_active, // Conversion stage running
  input wire logic [7:0] lat, // Cycles before the done pulse
  output logic convert_done // One-cycle completion pulse
);
  logic [7:0] cnt_q;

  // The count restarts after every pulse, because a second pass may enter
  // conversion again without an idle cycle in between.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 8'h00;
      convert_done <= 1'b0;
    end else if (!convert_active || convert_done) begin
      cnt_q <= 8'h00;
      convert_done <= 1'b0;
    end else if (cnt_q == lat) begin
      convert_done <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule

// [testbench/cvd_sequence_control_tb.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module cvd_sequence_control_tb;
  import cvd_pkg::*;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, lat;
  logic [31:0] pwdata, prdata, rd_q;
  logic err_q, rc_clk, convert_done, convert_active, result_select;
  cvd_pins_s pins;
  int n_errors, n_tests, n;

  cvd_sequence_control u_cvd_sequence_control (.pclk(pclk),
    .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rc_clk_pin(rc_clk),
    .convert_done(convert_done), .convert_active(convert_active),
    .result_select(result_select), .pins(pins));
  cvd_conv_model u_cvd_conv_model (.pclk(pclk), .presetn(presetn),
    .convert_active(convert_active), .lat(lat),
    .convert_done(convert_done));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // The oscillator runs on its own, out of phase with pclk.
  initial begin
    rc_clk = 1'b0;
    #3;
    forever #20 rc_clk = ~rc_clk;
  end

  task automatic end_of_test();
    if (n_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      n_errors++;
      end_of_test();
    end
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd_q, e)
  endtask

  function automatic logic cond(input int s);
    case (s)
      0: return pins.ext_precharge_active;
      1: return !pins.ext_precharge_active;
      2: return convert_active;
      default: return !convert_active;
    endcase
  endfunction

  // Counts edges until the condition holds, seen just before each edge.
  task automatic wait_for(input int s);
    n = 0;
    while (cond(s) !== 1'b1 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 2000) begin
      n_errors++;
      end_of_test();
    end
  endtask

  task automatic run_pass(input int pre, input int acq, input logic ext,
    input logic inp, input logic gpol, input logic idx,
    input logic [31:0] ctl);
    if (pre > 0) begin
      wait_for(0);
      `CHK(pins.ext_precharge_level, ext)
      `CHK(pins.int_precharge_active, 1'b1)
      `CHK(pins.int_precharge_level, inp)
      `CHK({pins.bus_pin_oe, pins.bus_pin_out}, {1'b1, inp})
      `CHK({pins.guard_a_out, pins.guard_b_out}, {gpol, gpol})
      wait_for(1);
      `CHK(n, pre)
      if (acq > 0) begin
        `CHK(pins.guard_a_out, ~gpol)
        wait_for(2);
        `CHK(n, acq)
      end
    end
    wait_for(2);
    `CHK(result_select, idx)
    rd_chk(CVD_OFF_STAGE_STATUS, {29'h0, idx, 2'b11});
    rd_chk(CVD_OFF_CONVERTER_CONTROL, ctl);
    wait_for(3);
  endtask

  task automatic scen_reset();
    for (int i = 0; i < 6; i++) begin
      rd_chk(8'(4 * i), 32'h0);
    end
    apb(1'b0, 8'h18, 32'h0);
    `CHK({err_q, rd_q}, {1'b1, 32'h0})
    wr(CVD_OFF_STAGE_STATUS, 32'h7);
    rd_chk(CVD_OFF_STAGE_STATUS, 32'h0);
  endtask

  task automatic scen_single();
    wr(CVD_OFF_PRECHARGE_TIME, 32'h7F);
    wr(CVD_OFF_ACQUISITION_TIME, 32'h1);
    wr(CVD_OFF_POLARITY_CONTROL, 32'h9A);
    wr(CVD_OFF_GUARD_RING_CONTROL, 32'hE0);
    wr(CVD_OFF_CONVERTER_CONTROL, 32'h3);
    run_pass(127, 1, 1'b1, 1'b0, 1'b1, 1'b0, 32'h3);
    rd_chk(CVD_OFF_CONVERTER_CONTROL, 32'h1);
    rd_chk(CVD_OFF_STAGE_STATUS, 32'h0);
    `CHK({pins.guard_a_oe, pins.guard_b_oe}, 2'b11)
    `CHK(pins.bus_pass_gate, 1'b1)
  endtask

  task automatic scen_double();
    wr(CVD_OFF_PRECHARGE_TIME, 32'h2);
    wr(CVD_OFF_POLARITY_CONTROL, 32'hDB);
    wr(CVD_OFF_CONVERTER_CONTROL, 32'h3);
    run_pass(2, 1, 1'b1, 1'b1, 1'b1, 1'b0, 32'h3);
    run_pass(2, 1, 1'b0, 1'b0, 1'b0, 1'b1, 32'h3);
    rd_chk(CVD_OFF_CONVERTER_CONTROL, 32'h1);
    rd_chk(CVD_OFF_POLARITY_CONTROL, 32'hDB);
  endtask

  // Both stages skipped, and the converter answers at once.
  task automatic scen_zero();
    lat <= 8'd0;
    wr(CVD_OFF_PRECHARGE_TIME, 32'h0);
    wr(CVD_OFF_ACQUISITION_TIME, 32'h0);
    wr(CVD_OFF_POLARITY_CONTROL, 32'h0);
    wr(CVD_OFF_CONVERTER_CONTROL, 32'h3);
    wait_for(2);
    `CHK(n <= 3, 1'b1)
    wait_for(3);
    rd_chk(CVD_OFF_CONVERTER_CONTROL, 32'h1);
    lat <= 8'd12;
  endtask

  // Two RC ticks of four pclk cycles each, give or take the synchroniser.
  task automatic scen_rc();
    wr(CVD_OFF_PRECHARGE_TIME, 32'h2);
    wr(CVD_OFF_CONVERTER_CONTROL, 32'h7);
    wait_for(0);
    wait_for(1);
    `CHK(n >= 4 && n <= 10, 1'b1)
    `CHK(convert_active, 1'b1)
    wait_for(3);
    rd_chk(CVD_OFF_CONVERTER_CONTROL, 32'h5);
  endtask

  task automatic scen_disable();
    wr(CVD_OFF_CONVERTER_CONTROL, 32'h2);
    rd_chk(CVD_OFF_CONVERTER_CONTROL, 32'h0);
    `CHK({pins.guard_a_oe, pins.guard_b_oe}, 2'b00)
    `CHK(pins.ext_precharge_active, 1'b0)
    wr(CVD_OFF_CONVERTER_CONTROL, 32'h1);
    wr(CVD_OFF_GUARD_RING_CONTROL, 32'h80);
    @(posedge pclk);
    `CHK({pins.guard_a_oe, pins.guard_b_oe}, 2'b01)
  endtask

  initial begin
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    lat = 8'd12;
    n_errors = 0;
    n_tests = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    scen_reset();
    scen_single();
    scen_double();
    scen_zero();
    scen_rc();
    scen_disable();
    end_of_test();
  end
endmodule
